// *** hdl/rrie_exec.v ***
// Executes return and byte-rotate instructions for the core
`timescale 1ns/1ps
`include "rrie_defines.vh"

module rrie_exec (
	input  wire                    ref_clk,
	input  wire                    sys_rst,
	input  wire                    clk_en,
	input  wire                    instr_valid,
	input  wire [2:0]              instr_op,
	input  wire                    rot_right,
	input  wire [7:0]              instr_imm,
	input  wire [8:0]              instr_addr,
	input  wire [7:0]              mem_rdata,
	input  wire [12:0]             stack_top,
	input  wire                    irq_pending,
	input  wire                    gie_clear,
	output reg  [7:0]              working_register_ff,
	output reg                     carry_ff,
	output reg                     global_irq_enable_ff,
	output reg  [12:0]             pc_ff,
	output reg                     pc_load_ff,
	output reg                     stack_pop_ff,
	output reg                     mem_we_ff,
	output reg  [8:0]              mem_waddr_ff,
	output reg  [7:0]              mem_wdata_ff,
	output reg                     irq_priority_ff
);

// ----------------------------------------
// Rotation datapath
// ----------------------------------------
// Memory read is combinational, so the rotations settle in the issue cycle
wire [7:0] rot_l;
wire [7:0] rot_r;
wire [7:0] rot_lc;

genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_rot
		if (gi == 0) begin : g_lsb
			assign rot_l[gi]  = mem_rdata[7];
			assign rot_lc[gi] = carry_ff;
		end else begin : g_up
			assign rot_l[gi]  = mem_rdata[gi-1];
			assign rot_lc[gi] = mem_rdata[gi-1];
		end
		if (gi == 7) begin : g_msb
			assign rot_r[gi] = mem_rdata[0];
		end else begin : g_dn
			assign rot_r[gi] = mem_rdata[gi+1];
		end
	end
endgenerate

// ----------------------------------------
// Instruction decode
// ----------------------------------------
wire go;
wire op_sub_exit;
wire op_sub_exit_li;
wire op_irq_exit;
wire op_return;
wire op_rot_mem;
wire op_rot_copy;
wire op_ring_mem;
wire op_ring_copy;
wire op_ring;

assign go             = instr_valid & clk_en;
assign op_sub_exit    = go & (instr_op == `RRIE_OP_SUB_EXIT);
assign op_sub_exit_li = go & (instr_op == `RRIE_OP_SUB_EXIT_LI);
assign op_irq_exit    = go & (instr_op == `RRIE_OP_IRQ_EXIT);
assign op_rot_mem     = go & (instr_op == `RRIE_OP_ROT_L_MEM);
assign op_rot_copy    = go & (instr_op == `RRIE_OP_ROT_L_COPY);
assign op_ring_mem    = go & (instr_op == `RRIE_OP_ROT_LC_MEM);
assign op_ring_copy   = go & (instr_op == `RRIE_OP_ROT_LC_CPY);
// One pop per return keeps nested calls balanced
assign op_return      = op_sub_exit | op_sub_exit_li | op_irq_exit;
assign op_ring        = op_ring_mem | op_ring_copy;

// ----------------------------------------
// Next values
// ----------------------------------------
reg [7:0]  nxt_working_register;
reg        nxt_carry;
reg        nxt_global_irq_enable;
reg [12:0] nxt_pc;
reg        nxt_pc_load;
reg        nxt_stack_pop;
reg        nxt_mem_we;
reg [8:0]  nxt_mem_waddr;
reg [7:0]  nxt_mem_wdata;
reg        nxt_irq_priority;

// ----------------------------------------
// Program flow
// ----------------------------------------
always @* begin
	nxt_pc        = pc_ff;
	nxt_pc_load   = 1'b0;
	nxt_stack_pop = 1'b0;
	if (op_return) begin
		nxt_pc        = stack_top;
		nxt_pc_load   = 1'b1;
		nxt_stack_pop = 1'b1;
	end
end

// ----------------------------------------
// Working register
// ----------------------------------------
// Plain exit and memory rotates leave it alone
always @* begin
	nxt_working_register = working_register_ff;
	if (op_sub_exit_li) begin
		nxt_working_register = instr_imm;
	end
	if (op_rot_copy) begin
		nxt_working_register = rot_l;
	end
	if (op_ring_copy) begin
		nxt_working_register = rot_lc;
	end
end

// ----------------------------------------
// Carry flag
// ----------------------------------------
// Only the ring rotates touch carry; every other op keeps it
always @* begin
	nxt_carry = carry_ff;
	if (op_ring) begin
		nxt_carry = mem_rdata[7];
	end
end

// ----------------------------------------
// Data memory write
// ----------------------------------------
always @* begin
	nxt_mem_we    = 1'b0;
	nxt_mem_waddr = mem_waddr_ff;
	nxt_mem_wdata = mem_wdata_ff;
	if (op_rot_mem) begin
		nxt_mem_we    = 1'b1;
		nxt_mem_waddr = instr_addr;
		nxt_mem_wdata = rot_right ? rot_r : rot_l;
	end
	if (op_ring_mem) begin
		nxt_mem_we    = 1'b1;
		nxt_mem_waddr = instr_addr;
		nxt_mem_wdata = rot_lc;
	end
end

// ----------------------------------------
// Interrupt enable and priority
// ----------------------------------------
// Clear first so that an interrupt exit in the same cycle wins
always @* begin
	nxt_global_irq_enable = global_irq_enable_ff;
	nxt_irq_priority      = 1'b0;
	if (gie_clear) begin
		nxt_global_irq_enable = 1'b0;
	end
	if (op_irq_exit) begin
		nxt_global_irq_enable = 1'b1;
		// Fetch must vector before the returned-to instruction
		nxt_irq_priority      = irq_pending;
	end
end

// ----------------------------------------
// State registers
// ----------------------------------------
// Clock enable low holds every register, pulses included
always @(posedge ref_clk or posedge sys_rst) begin
	if (sys_rst) begin
		working_register_ff  <= `RRIE_WREG_RST;
		carry_ff             <= `RRIE_CARRY_RST;
		global_irq_enable_ff <= `RRIE_GIE_RST;
		pc_ff                <= `RRIE_PC_RST;
		pc_load_ff           <= 1'b0;
		stack_pop_ff         <= 1'b0;
		mem_we_ff            <= 1'b0;
		mem_waddr_ff         <= 9'h000;
		mem_wdata_ff         <= 8'h00;
		irq_priority_ff      <= 1'b0;
	end else if (clk_en) begin
		working_register_ff  <= nxt_working_register;
		carry_ff             <= nxt_carry;
		global_irq_enable_ff <= nxt_global_irq_enable;
		pc_ff                <= nxt_pc;
		pc_load_ff           <= nxt_pc_load;
		stack_pop_ff         <= nxt_stack_pop;
		mem_we_ff            <= nxt_mem_we;
		mem_waddr_ff         <= nxt_mem_waddr;
		mem_wdata_ff         <= nxt_mem_wdata;
		irq_priority_ff      <= nxt_irq_priority;
	end
end

// ----------------------------------------
// Usage limits
// ----------------------------------------
// Flags other than carry are not held here, so
// they stay untouched by every op of this block.
// A refused cycle (clock enable low) drops the
// instruction; the issuer must hold it and retry.
// Right rotate shares the memory rotate opcode
// and is chosen by the separate direction input.
// Data memory must be read combinationally at
// the instruction address in the issue cycle.

endmodule

// *** hdl/rrie_defines.vh ***
// Constants for the return and rotate instruction executor
`ifndef RRIE_DEFINES_VH
`define RRIE_DEFINES_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define RRIE_OP_W          3
`define RRIE_OP_NONE       3'h0
`define RRIE_OP_SUB_EXIT   3'h1
`define RRIE_OP_SUB_EXIT_LI 3'h2
`define RRIE_OP_IRQ_EXIT   3'h3
`define RRIE_OP_ROT_L_MEM  3'h4
`define RRIE_OP_ROT_L_COPY 3'h5
`define RRIE_OP_ROT_LC_MEM 3'h6
`define RRIE_OP_ROT_LC_CPY 3'h7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define RRIE_PC_W          13
`define RRIE_ADDR_W        9
`define RRIE_WREG_RST      8'h00
`define RRIE_CARRY_RST     1'b0
`define RRIE_GIE_RST       1'b0
`define RRIE_PC_RST        13'h0000

`endif

// *** verification/rrie_exec_chk.sv ***
// Port checker for the return and rotate executor
`timescale 1ns/1ps
module rrie_chk (input wire ref_clk, sys_rst, clk_en, instr_valid, rot_right, irq_pending,
	gie_clear, input wire [8:0] instr_addr, mem_waddr_ff, input wire
	carry_ff, global_irq_enable_ff, pc_load_ff, stack_pop_ff, mem_we_ff, irq_priority_ff,
	input wire [2:0] instr_op, input wire [7:0] instr_imm, mem_rdata, working_register_ff,
	mem_wdata_ff, input wire [12:0] stack_top, pc_ff);
	wire t = clk_en & instr_valid;
	wire [7:0] m = mem_rdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_rot_left_mem: assert property (t && instr_op == 4 && !rot_right |=> mem_we_ff &&
		$stable(carry_ff) && mem_waddr_ff == $past(instr_addr) &&
		mem_wdata_ff == {$past(m[6:0]), $past(m[7])}) else $error("rotate left bad");
	a_rot_right_mem: assert property (t && instr_op == 4 && rot_right |=> mem_we_ff &&
		mem_wdata_ff == {$past(m[0]), $past(m[7:1])}) else $error("rotate right bad");
	a_rot_copy: assert property (t && instr_op == 5 |=> !mem_we_ff && $stable(carry_ff) &&
		working_register_ff == {$past(m[6:0]), $past(m[7])}) else $error("copy bad");
	a_ring_mem: assert property (t && instr_op == 6 |=> mem_we_ff &&
		{carry_ff, mem_wdata_ff} == {$past(m), $past(carry_ff)}) else $error("ring bad");
	a_ring_copy: assert property (t && instr_op == 7 |=> !mem_we_ff &&
		{carry_ff, working_register_ff} == {$past(m), $past(carry_ff)}) else $error("ring copy");
	a_exit_load: assert property (t && instr_op == 2 |=> pc_load_ff && $stable(carry_ff) &&
		pc_ff == $past(stack_top) && working_register_ff == $past(instr_imm)) else $error("exit li");
	a_irq_exit: assert property (t && instr_op == 3 |=> global_irq_enable_ff &&
		$stable(carry_ff) && stack_pop_ff &&
		pc_ff == $past(stack_top) && irq_priority_ff == $past(irq_pending)) else $error("irq exit");
	a_plain_exit: assert property (t && instr_op == 1 |=> pc_load_ff &&
		pc_ff == $past(stack_top) && $stable(working_register_ff) && $stable(carry_ff))
		else $error("exit bad");
	a_gie_clear: assert property (clk_en && gie_clear && !(t && instr_op == 3) |=>
		!global_irq_enable_ff) else $error("enable clear bad");
	a_freeze_hold: assert property (!clk_en |=> $stable(pc_ff) && $stable(carry_ff) &&
		$stable(working_register_ff) && $stable(stack_pop_ff)) else $error("freeze bad");
	a_one_pop: assert property (clk_en |=> stack_pop_ff ==
		$past(t && instr_op != 0 && instr_op < 4)) else $error("pop count bad");
endmodule
bind rrie_exec rrie_chk u_chk (.*);

// *** verification/rrie_exec_tb.sv ***
// Random bench for the return and rotate executor
`timescale 1ns/1ps
module rrie_exec_tb;
	reg ref_clk = 0, sys_rst = 1, clk_en = 1, instr_valid = 0, rot_right = 0, irq_pending = 0;
	reg gie_clear = 0, ec = 0, eg = 0, tk, rt, mw;
	reg [2:0] instr_op = 0;
	reg [7:0] instr_imm = 0, mem_rdata = 0, ew = 0, ed = 0;
	reg [8:0] instr_addr = 0, ea = 0;
	reg [12:0] stack_top = 0;
	reg [31:0] seed = 32'hb11f;
	integer i, num_errors = 0, n_tests = 0;
	wire [7:0] working_register_ff, mem_wdata_ff;
	wire carry_ff, global_irq_enable_ff, pc_load_ff, stack_pop_ff, mem_we_ff, irq_priority_ff;
	wire [12:0] pc_ff;
	wire [8:0] mem_waddr_ff;
	rrie_exec dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr_op(instr_op), .rot_right(rot_right),
		.instr_imm(instr_imm), .instr_addr(instr_addr), .mem_rdata(mem_rdata),
		.stack_top(stack_top), .irq_pending(irq_pending), .gie_clear(gie_clear),
		.working_register_ff(working_register_ff), .carry_ff(carry_ff),
		.global_irq_enable_ff(global_irq_enable_ff), .pc_ff(pc_ff), .pc_load_ff(pc_load_ff),
		.stack_pop_ff(stack_pop_ff), .mem_we_ff(mem_we_ff), .mem_waddr_ff(mem_waddr_ff),
		.mem_wdata_ff(mem_wdata_ff), .irq_priority_ff(irq_priority_ff));
	function [31:0] xs(input [31:0] s); begin
		xs = s ^ (s << 13); xs = xs ^ (xs >> 17); xs = xs ^ (xs << 5);
	end endfunction
	task check(input [15:0] s, input [15:0] e); begin
		n_tests = n_tests + 1;
		if (s !== e) begin num_errors = num_errors + 1; $display("Error %0t: %h vs %h", $time, s, e); end
	end endtask
	task wrap_up; begin
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end endtask
	initial forever #50 ref_clk = ~ref_clk;
	initial begin #200000; num_errors = num_errors + 1; wrap_up; end
	initial begin
		tk = 0; rt = 0; mw = 0;
		repeat (10) @(posedge ref_clk);
		for (i = 0; i < 400; i = i + 1) begin
			@(negedge ref_clk) sys_rst = 0;
			check(working_register_ff, ew);
			check(carry_ff, ec);
			if (clk_en) check(stack_pop_ff, rt);
			if (clk_en) check(mem_we_ff, mw);
			if (rt) check(pc_ff, stack_top);
			if (tk && instr_op == 3) check(irq_priority_ff, irq_pending);
			if (mw) check(mem_wdata_ff, ed);
			if (mw) check(mem_waddr_ff, ea);
			if (clk_en) check(pc_load_ff, rt);
			check(global_irq_enable_ff, eg);
			seed = xs(seed);
			{instr_op, rot_right, instr_imm, mem_rdata, irq_pending, gie_clear} = seed[21:0];
			{instr_valid, clk_en} = seed[31:30] | {1'b0, seed[29]};
			if (i < 8) {instr_op, instr_valid, clk_en, mem_rdata} = {i[2:0], 2'h3, 8'h81};
			seed = xs(seed);
			{stack_top, instr_addr} = seed[21:0];
			tk = clk_en & instr_valid;
			rt = tk && instr_op != 0 && instr_op < 4;
			mw = tk && instr_op[2] && !instr_op[0];
			if (clk_en && gie_clear) eg = 0;
			if (tk && instr_op == 3) eg = 1;
			if (tk) case (instr_op)
				2: ew = instr_imm;
				4: begin ea = instr_addr;
					ed = rot_right ? {mem_rdata[0], mem_rdata[7:1]} : {mem_rdata[6:0], mem_rdata[7]};
				end
				5: ew = {mem_rdata[6:0], mem_rdata[7]};
				6, 7: begin ea = instr_addr; ed = {mem_rdata[6:0], ec}; ec = mem_rdata[7];
					if (instr_op[0]) ew = ed; end
			endcase
			// Mid-run reset: held across one rising edge, released at next falling edge
			if (i == 200) begin sys_rst = 1; tk = 0; rt = 0; mw = 0; ew = 0; ec = 0; eg = 0; end
		end
		wrap_up;
	end
endmodule
